// file: rtl/usbf_pkg.sv
// Package with the constants of the serial port buffer and flag block.
package usbf_pkg;
  localparam int          DATA_W          = 8;
  localparam logic [7:0]  SFR_DATA_ADDR   = 8'h99;
  localparam logic [7:0]  SFR_CTRL_ADDR   = 8'h98;
  localparam int          CTRL_TX_DONE    = 1;
  localparam int          CTRL_RX_DONE    = 0;
  localparam int          CTRL_NINE_BIT   = 3;
  localparam logic [7:0]  DATA_RESET      = 8'h00;
  localparam int          FIFO_DEPTH      = 16;
  localparam logic [15:0] BIT_DIV_DEFAULT = 16'h0004;
  localparam logic [3:0]  DATA_BITS       = 4'h8;
endpackage : usbf_pkg

// file: rtl/usbf_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/100ps
module usbf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             core_clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];

  always_comb begin
    push        = in_valid && in_ready;
    pop         = out_valid && out_ready;
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule : usbf_fifo

// file: rtl/usbf_port.sv
// Serial port data buffer, transmit and receive engines and done flags.
`timescale 1ns/100ps
//////////////////////////////////////////////////////////////////////////////////
// How it works
// - Transmit done after bit eight, or stop start.
// - Interrupt request while enabled flag is set.
// - Transmit done flag cleared only by software.
// - Data write pushes into the 16-entry transmit FIFO.
// - Every byte written while sfr_wr_ready is high starts a new transmission.
// - Data read returns the receive latch.
// - One 8-bit location, all pages, resets zero.
module usbf_port
  import usbf_pkg::*;
#(
  parameter logic [15:0] BIT_DIV = usbf_pkg::BIT_DIV_DEFAULT
) (
  input  wire logic       core_clk,
  input  wire logic       resetn,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  output logic            sfr_wr_ready,
  input  wire logic       irq_enable,
  output logic            irq_request,
  output logic            tx_line,
  input  wire logic       rx_line
);
  import usbf_pkg::*;

  typedef enum {TX_IDLE, TX_START, TX_DATA, TX_NINTH, TX_STOP} usbf_tx_state_t;
  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_NINTH, RX_STOP} usbf_rx_state_t;

  //////////////////////////////////////////////////////////////////////////////////
  // Register access.
  logic       data_sel;
  logic       ctrl_sel;
  logic [7:0] ctrl_reg;
  logic       fifo_out_valid;
  logic       fifo_out_ready;
  logic [7:0] fifo_out_data;
  logic [7:0] rx_latch;
  logic       tx_done_flag;
  logic       rx_done_flag;
  logic       nine_bit;
  logic       set_tx_done;
  logic       set_rx_done;
  logic [7:0] next_sfr_rdata;

  assign data_sel = (sfr_addr == SFR_DATA_ADDR);
  assign ctrl_sel = (sfr_addr == SFR_CTRL_ADDR);
  assign ctrl_reg = {4'h0, nine_bit, 1'b0, tx_done_flag, rx_done_flag};
  assign irq_request = irq_enable && (tx_done_flag || rx_done_flag);

  always_comb begin
    next_sfr_rdata = sfr_rdata;
    if (sfr_rd && data_sel) begin
      next_sfr_rdata = rx_latch;
    end else if (sfr_rd && ctrl_sel) begin
      next_sfr_rdata = ctrl_reg;
    end else if (sfr_rd) begin
      next_sfr_rdata = 8'h00;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sfr_rdata <= DATA_RESET;
    end else begin
      sfr_rdata <= next_sfr_rdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////
  // Flags and mode.
  logic next_tx_done_flag;
  logic next_rx_done_flag;
  logic next_nine_bit;
  logic ctrl_wr;

  always_comb begin
    ctrl_wr           = sfr_wr && ctrl_sel;
    next_tx_done_flag = tx_done_flag;
    next_rx_done_flag = rx_done_flag;
    next_nine_bit     = nine_bit;
    if (ctrl_wr) begin
      next_tx_done_flag = sfr_wdata[CTRL_TX_DONE];
      next_rx_done_flag = sfr_wdata[CTRL_RX_DONE];
      next_nine_bit     = sfr_wdata[CTRL_NINE_BIT];
    end
    if (set_tx_done) begin
      next_tx_done_flag = 1'b1;
    end
    if (set_rx_done) begin
      next_rx_done_flag = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tx_done_flag <= 1'b0;
      rx_done_flag <= 1'b0;
      nine_bit     <= 1'b0;
    end else begin
      tx_done_flag <= next_tx_done_flag;
      rx_done_flag <= next_rx_done_flag;
      nine_bit     <= next_nine_bit;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////
  // Transmit path.
  usbf_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .core_clk  (core_clk),
    .resetn    (resetn),
    .in_data   (sfr_wdata),
    .in_valid  (sfr_wr && data_sel),
    .in_ready  (sfr_wr_ready),
    .out_data  (fifo_out_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready)
  );

  usbf_tx_state_t tx_state;
  usbf_tx_state_t next_tx_state;
  logic [7:0]     tx_shift;
  logic [7:0]     next_tx_shift;
  logic [15:0]    tx_cnt;
  logic [15:0]    next_tx_cnt;
  logic [3:0]     tx_bits;
  logic [3:0]     next_tx_bits;
  logic           next_tx_line;
  logic           tx_tick;

  always_comb begin
    tx_tick        = (tx_cnt == BIT_DIV - 16'h0001);
    next_tx_state  = tx_state;
    next_tx_shift  = tx_shift;
    next_tx_bits   = tx_bits;
    next_tx_line   = tx_line;
    next_tx_cnt    = tx_tick ? 16'h0000 : tx_cnt + 16'h0001;
    fifo_out_ready = 1'b0;
    set_tx_done    = 1'b0;
    case (tx_state)
      TX_IDLE: begin
        next_tx_cnt  = 16'h0000;
        next_tx_line = 1'b1;
        if (fifo_out_valid) begin
          fifo_out_ready = 1'b1;
          next_tx_shift  = fifo_out_data;
          next_tx_line   = 1'b0;
          next_tx_state  = TX_START;
        end
      end
      TX_START: if (tx_tick) begin
        next_tx_line  = tx_shift[0];
        next_tx_shift = {1'b0, tx_shift[7:1]};
        next_tx_bits  = 4'h1;
        next_tx_state = TX_DATA;
      end
      TX_DATA: if (tx_tick) begin
        if (tx_bits == DATA_BITS) begin
          next_tx_line  = nine_bit ? 1'b0 : 1'b1;
          next_tx_state = nine_bit ? TX_NINTH : TX_STOP;
          set_tx_done   = !nine_bit;
        end else begin
          next_tx_line  = tx_shift[0];
          next_tx_shift = {1'b0, tx_shift[7:1]};
          next_tx_bits  = tx_bits + 4'h1;
        end
      end
      TX_NINTH: if (tx_tick) begin
        next_tx_line  = 1'b1;
        set_tx_done   = 1'b1;
        next_tx_state = TX_STOP;
      end
      TX_STOP: if (tx_tick) begin
        next_tx_state = TX_IDLE;
      end
      default: next_tx_state = TX_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tx_state <= TX_IDLE;
      tx_shift <= DATA_RESET;
      tx_cnt   <= 16'h0000;
      tx_bits  <= 4'h0;
      tx_line  <= 1'b1;
    end else begin
      tx_state <= next_tx_state;
      tx_shift <= next_tx_shift;
      tx_cnt   <= next_tx_cnt;
      tx_bits  <= next_tx_bits;
      tx_line  <= next_tx_line;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////
  // Receive path.
  usbf_rx_state_t rx_state;
  usbf_rx_state_t next_rx_state;
  logic [7:0]     rx_shift;
  logic [7:0]     next_rx_shift;
  logic [7:0]     next_rx_latch;
  logic [15:0]    rx_cnt;
  logic [15:0]    next_rx_cnt;
  logic [3:0]     rx_bits;
  logic [3:0]     next_rx_bits;
  logic           rx_tick;
  logic           rx_mid;

  always_comb begin
    rx_tick       = (rx_cnt == BIT_DIV - 16'h0001);
    rx_mid        = (rx_cnt == {1'b0, BIT_DIV[15:1]});
    next_rx_state = rx_state;
    next_rx_shift = rx_shift;
    next_rx_latch = rx_latch;
    next_rx_bits  = rx_bits;
    next_rx_cnt   = rx_tick ? 16'h0000 : rx_cnt + 16'h0001;
    set_rx_done   = 1'b0;
    case (rx_state)
      RX_IDLE: begin
        next_rx_cnt = 16'h0000;
        if (!rx_line) begin
          next_rx_state = RX_START;
        end
      end
      RX_START: if (rx_mid) begin
        next_rx_state = rx_line ? RX_IDLE : RX_DATA;
        next_rx_bits  = 4'h0;
      end
      RX_DATA: if (rx_mid) begin
        next_rx_shift = {rx_line, rx_shift[7:1]};
        next_rx_bits  = rx_bits + 4'h1;
        if (rx_bits == DATA_BITS - 4'h1) begin
          next_rx_state = nine_bit ? RX_NINTH : RX_STOP;
        end
      end
      RX_NINTH: if (rx_mid) begin
        next_rx_state = RX_STOP;
      end
      RX_STOP: if (rx_mid) begin
        next_rx_latch = rx_shift;
        set_rx_done   = 1'b1;
        next_rx_state = RX_IDLE;
      end
      default: next_rx_state = RX_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rx_state <= RX_IDLE;
      rx_shift <= DATA_RESET;
      rx_latch <= DATA_RESET;
      rx_cnt   <= 16'h0000;
      rx_bits  <= 4'h0;
    end else begin
      rx_state <= next_rx_state;
      rx_shift <= next_rx_shift;
      rx_latch <= next_rx_latch;
      rx_cnt   <= next_rx_cnt;
      rx_bits  <= next_rx_bits;
    end
  end
endmodule : usbf_port

// file: verification/usbf_port_sva.sv
// Assertion checker for the serial port buffer and flag block.
`timescale 1ns/100ps
module usbf_port_chk
  import usbf_pkg::*;
#(
  parameter logic [15:0] BIT_DIV = 16'h0004
) (
  input wire logic       core_clk,
  input wire logic       resetn,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic       sfr_wr_ready,
  input wire logic       irq_enable,
  input wire logic       irq_request,
  input wire logic       tx_line,
  input wire logic       rx_line
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  irq_mask_a: assert property (!irq_enable |-> !irq_request)
    else $error("request while disabled");
  flag_sticky_a: assert property (irq_request && irq_enable && !sfr_wr
    |=> irq_request || !irq_enable)
    else $error("flag dropped alone");
  write_starts_a: assert property (sfr_wr && sfr_addr == SFR_DATA_ADDR && sfr_wr_ready
    |-> ##[1:1000] !tx_line)
    else $error("no frame after write");
  read_hold_a: assert property (!sfr_rd |=> $stable(sfr_rdata))
    else $error("read data moved");
  unmapped_zero_a: assert property (sfr_rd && sfr_addr != SFR_DATA_ADDR
    && sfr_addr != SFR_CTRL_ADDR |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  low_bit_a: assert property ($fell(tx_line) |-> !tx_line[*4])
    else $error("low bit too short");
  high_bit_a: assert property ($rose(tx_line) |-> tx_line[*4])
    else $error("high bit too short");
  reset_state_a: assert property ($rose(resetn)
    |-> tx_line && sfr_wr_ready && sfr_rdata == 8'h00)
    else $error("bad state after reset");
endmodule : usbf_port_chk
bind usbf_port usbf_port_chk #(.BIT_DIV(BIT_DIV)) usbf_port_chk_inst (.core_clk(core_clk),
  .resetn(resetn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
  .sfr_rdata(sfr_rdata), .sfr_wr_ready(sfr_wr_ready), .irq_enable(irq_enable),
  .irq_request(irq_request), .tx_line(tx_line), .rx_line(rx_line));

// file: verification/usbf_remote.sv
// Remote serial node: decodes transmitted frames and sends frames back.
`timescale 1ns/100ps
module usbf_remote #(
  parameter int BIT_DIV = 4
) (
  input  wire logic core_clk,
  input  wire logic tx_line,
  output logic      rx_line
);
  logic [7:0] got[$];
  logic [7:0] b;
  initial rx_line = 1'b1;
  always begin
    @(negedge tx_line);
    repeat (BIT_DIV / 2) @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_DIV) @(posedge core_clk);
      b[i] = tx_line;
    end
    repeat (BIT_DIV) @(posedge core_clk);
    got.push_back(b);
  end
  task automatic send(input logic [7:0] d, input logic nine);
    @(posedge core_clk);
    #2;
    for (int k = 0; k < 10 + nine; k++) begin
      rx_line = (k == 0) ? 1'b0 : (k <= 8) ? d[k-1] : 1'b1;
      repeat (BIT_DIV) @(posedge core_clk);
      #2;
    end
  endtask : send
endmodule : usbf_remote

// file: verification/testbench.sv
// Self-checking testbench of the serial port buffer and flag block.
`timescale 1ns/100ps
module testbench;
  import usbf_pkg::*;
  logic       core_clk = 1'b0;
  logic       resetn;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, c, t, r, d;
  logic       sfr_wr, sfr_rd, sfr_wr_ready, irq_enable, irq_request, tx_line, rx_line, ok;
  int         errors = 0;
  int         check_count = 0;
  int         n, k;
  logic [23:0] rows[4] = '{24'h00A53C, 24'h000180, 24'h08FF00, 24'h085AC3};
  always #12.5 core_clk = ~core_clk;
  usbf_port #(.BIT_DIV(16'h0004)) usbf_port_inst (.core_clk(core_clk), .resetn(resetn),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .sfr_wr_ready(sfr_wr_ready), .irq_enable(irq_enable),
    .irq_request(irq_request), .tx_line(tx_line), .rx_line(rx_line));
  usbf_remote #(.BIT_DIV(4)) usbf_remote_inst (.core_clk(core_clk), .tx_line(tx_line),
    .rx_line(rx_line));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] v, output logic acc);
    @(posedge core_clk);
    #2;
    sfr_addr = a;
    sfr_wdata = v;
    sfr_wr = 1'b1;
    acc = sfr_wr_ready;
    @(posedge core_clk);
    #2;
    sfr_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge core_clk);
    #2;
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge core_clk);
    #2;
    sfr_rd = 1'b0;
    v = sfr_rdata;
  endtask : rd
  task automatic wait_irq(output int cnt);
    cnt = 0;
    while (irq_request !== 1'b1 && cnt < 1000) begin
      @(posedge core_clk);
      #2;
      cnt++;
    end
  endtask : wait_irq
  task automatic end_of_test;
    if (errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    #(20000 * 25);
    errors++;
    end_of_test();
  end
  initial begin
    {resetn, sfr_wr, sfr_rd, sfr_addr, sfr_wdata, irq_enable} = {3'b000, 16'h0000, 1'b1};
    repeat (3) @(posedge core_clk);
    #2 resetn = 1'b1;
    foreach (rows[i]) begin
      {c, t, r} = rows[i];
      wr(SFR_CTRL_ADDR, c, ok);
      wr(SFR_DATA_ADDR, t, ok);
      wait_irq(n);
      check(8'(n >= 35 + 4 * c[3] && n <= 38 + 4 * c[3]), 8'h01);
      repeat (8) @(posedge core_clk);
      #2;
      check(usbf_remote_inst.got.pop_front(), t);
      check(8'(irq_request), 8'h01);
      rd(SFR_CTRL_ADDR, d);
      check(d, c | (8'h01 << CTRL_TX_DONE));
      wr(SFR_CTRL_ADDR, c, ok);
      check(8'(irq_request), 8'h00);
      usbf_remote_inst.send(r, c[3]);
      wait_irq(n);
      check(8'(irq_request), 8'h01);
      rd(SFR_DATA_ADDR, d);
      check(d, r);
      rd(SFR_CTRL_ADDR, d);
      check(d, c | (8'h01 << CTRL_RX_DONE));
      wr(SFR_CTRL_ADDR, c, ok);
    end
    irq_enable = 1'b0;
    usbf_remote_inst.send(8'h77, 1'b0);
    repeat (8) @(posedge core_clk);
    #2;
    check(8'(irq_request), 8'h00);
    irq_enable = 1'b1;
    #1 check(8'(irq_request), 8'h01);
    rd(SFR_DATA_ADDR, d);
    check(d, 8'h77);
    rd(8'h55, d);
    check(d, 8'h00);
    wr(SFR_CTRL_ADDR, 8'h00, ok);
    k = 0;
    ok = 1'b1;
    while (ok && k < 20) begin
      wr(SFR_DATA_ADDR, 8'h10 + 8'(k), ok);
      if (ok) k++;
    end
    check(8'(k >= 16 && k <= 18), 8'h01);
    n = 0;
    while (usbf_remote_inst.got.size() < k && n < 2000) begin
      @(posedge core_clk);
      n++;
    end
    repeat (60) @(posedge core_clk);
    check(8'(usbf_remote_inst.got.size()), 8'(k));
    for (int j = 0; j < k; j++) check(usbf_remote_inst.got.pop_front(), 8'h10 + 8'(j));
    wr(SFR_DATA_ADDR, 8'hAA, ok);
    repeat (10) @(posedge core_clk);
    #2 resetn = 1'b0;
    repeat (2) @(posedge core_clk);
    #2 resetn = 1'b1;
    check({6'h00, tx_line, sfr_wr_ready}, 8'h03);
    rd(SFR_DATA_ADDR, d);
    check(d, 8'h00);
    end_of_test();
  end
endmodule : testbench
